// ==== inc/adsq_pkg.sv ====
// shared constants and types of the converter sequencer control
package adsq_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 32;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTL       = 16'h1030;
    localparam logic [15:0] IDX_RES1      = 16'h1031;
    localparam logic [15:0] IDX_OPT       = 16'h1039;
    localparam int          NUM_RES       = 4;
    localparam logic [7:0]  CTL_RST       = 8'h80;
    localparam logic [7:0]  OPT_RST       = 8'h10;
    localparam int          CTL_CCF       = 7;
    localparam int          CTL_ZERO      = 6;
    localparam int          CTL_SCAN      = 5;
    localparam int          CTL_CHANNEL_GROUP_CTRL      = 4;
    localparam logic [7:0]  CTL_WR_MASK   = 8'h3f;
    localparam int          OPT_CONVERTER_POWER_UP      = 7;
    localparam int          OPT_CONVERTER_CLOCK_SOURCE      = 6;
    // bits that take one write only, early after reset
    localparam logic [7:0]  OPT_ONCE_MASK = 8'h37;
    localparam logic [7:0]  OPT_FREE_MASK = 8'hc8;
    localparam logic [6:0]  LOCK_CYC      = 7'h40;
    localparam int          SAMPLE_TICKS  = 12;
    localparam int          BIT_TICKS     = 2;
    localparam int          SYS_HZ        = 200_000_000;
    localparam int          E_HZ          = 2_000_000;
    localparam int          E_DIV         = SYS_HZ / E_HZ;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_SAMPLE,
        ST_BITS,
        ST_STORE,
        ST_SUSP
    } adsq_state_t;

    function automatic logic [15:0] adsq_byte_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction
endpackage

// ==== src/adsq_top.sv ====
// converter sequencer control with apb register access
// Contract
// - four readable 8-bit result registers
// - results updated only when no read
// - clock source bit picks e or rc
// - sequences of four, once or repeated
// - complete flag set after fourth conversion
// - power-up bit 7 enables converter
// - sequence starts one e cycle after write
// - low ref gives 00, high gives ff
// - 4-bit select, group results by position
// - single once: four results then halt
// - single repeat: round-robin overwrite results
// - group once: four channels then halt
// - group repeat: cycle group round-robin
// - stop/wait suspends, resume resamples channel
// - flag read-only, bit 6 reads zero
// - write mid-sequence restarts with new settings
// - every control write clears flag, starts only when powered up
// - repeat mode keeps flag set after first
// - marked option bits write once early
// - result registers ignore writes
// - group mode uses upper two select bits
`timescale 1ns/1ps
module adsq_top #(
    parameter int E_DIV = adsq_pkg::E_DIV
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [adsq_pkg::ADDR_W-1:0] paddr,
    input  wire logic [adsq_pkg::DATA_W-1:0] pwdata,
    output logic      [adsq_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        special_mode,
    input  wire logic                        stop_mode,
    input  wire logic                        wait_mode,
    input  wire logic                        rc_osc,
    input  wire logic                        cmp_in,
    output logic      [3:0]                  mux_sel,
    output logic                             sample_en,
    output logic      [7:0]                  dac_code,
    output logic                             conv_pwr,
    output logic                             conv_clk_rc
);
    import adsq_pkg::*;

    // elaboration check: the tick counter is 16 bits wide
    if (E_DIV < 2 || E_DIV > 65535) begin : g_bad_div
        $error("E_DIV out of range");
    end

    adsq_state_t state_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [7:0]  ctl_ff;
    logic [7:0]  opt_ff;
    logic [7:0]  res_ff [NUM_RES];
    logic [6:0]  lock_cnt_ff;
    logic        once_done_ff;
    logic [15:0] e_cnt_ff;
    logic        e_tick_ff;
    logic [2:0]  rc_sync_ff;
    logic        rc_lvl_ff;
    logic [2:0]  cmp_sync_ff;
    logic        cmp_lvl_ff;
    logic [3:0]  tcnt_ff;
    logic [2:0]  bit_ff;
    logic [1:0]  slot_ff;
    logic [7:0]  sar_ff;
    logic [3:0]  mux_sel_ff;
    logic        sample_en_ff;
    logic [7:0]  dac_code_ff;

    logic        access;
    logic        wr_ctl;
    logic        wr_opt;
    logic        hit_ctl;
    logic        hit_opt;
    logic        hit_res;
    logic [15:0] res_off;
    logic        rc_rise;
    logic        conv_tick;
    logic        susp;
    logic        commit;
    logic        opt_open;

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign mux_sel     = mux_sel_ff;
    assign sample_en   = sample_en_ff;
    assign dac_code    = dac_code_ff;
    assign conv_pwr    = opt_ff[OPT_CONVERTER_POWER_UP];
    assign conv_clk_rc = opt_ff[OPT_CONVERTER_CLOCK_SOURCE];

    // ---------------- apb decode ----------------
    assign res_off = paddr - adsq_byte_addr(IDX_RES1);
    assign hit_ctl = (paddr == adsq_byte_addr(IDX_CTL));
    assign hit_opt = (paddr == adsq_byte_addr(IDX_OPT));
    assign hit_res = (res_off[15:4] == 12'h000) && (res_off[1:0] == 2'b00);
    // write takes effect only at the edge where pready is seen high
    assign access  = psel & penable & pready_ff;
    assign wr_ctl  = access & pwrite & hit_ctl;
    assign wr_opt  = access & pwrite & hit_opt;

    function automatic logic [7:0] rd_mux(input logic [15:0] off,
                                          input logic        c,
                                          input logic        o,
                                          input logic        r);
        logic [7:0] v;
        v = 8'h00;
        if (c) begin
            v = ctl_ff & ~(8'h01 << CTL_ZERO);
        end else if (o) begin
            v = opt_ff;
        end else if (r) begin
            v = res_ff[off[3:2]];
        end
        return v;
    endfunction

    // zero wait state: pready rises in the access cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~(hit_ctl | hit_opt | hit_res);
            if (psel && !penable && !pwrite) begin
                prdata_ff <= {24'h00_0000,
                              rd_mux(res_off, hit_ctl, hit_opt, hit_res)};
            end
        end
    end

    // ---------------- option register ----------------
    assign opt_open = special_mode
                      || (!once_done_ff && lock_cnt_ff < LOCK_CYC);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lock_cnt_ff <= 7'h00;
        end else if (lock_cnt_ff < LOCK_CYC) begin
            lock_cnt_ff <= lock_cnt_ff + 7'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            opt_ff       <= OPT_RST;
            once_done_ff <= 1'b0;
        end else if (wr_opt) begin
            // power-up and clock source always writable
            opt_ff <= (opt_ff & ~OPT_FREE_MASK)
                      | (pwdata[7:0] & OPT_FREE_MASK);
            // one early write, or any time in special mode
            if (opt_open) begin
                opt_ff[5:0] <= (pwdata[5:0] & OPT_ONCE_MASK[5:0])
                               | (pwdata[5:0] & OPT_FREE_MASK[5:0]);
                once_done_ff <= 1'b1;
            end
        end
    end

    // ---------------- converter clocks ----------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            e_cnt_ff  <= 16'h0000;
            e_tick_ff <= 1'b0;
        end else if (e_cnt_ff == 16'(E_DIV - 1)) begin
            e_cnt_ff  <= 16'h0000;
            e_tick_ff <= 1'b1;
        end else begin
            e_cnt_ff  <= e_cnt_ff + 16'h0001;
            e_tick_ff <= 1'b0;
        end
    end

    // rc oscillator and comparator come from outside this clock
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rc_sync_ff  <= 3'b000;
            rc_lvl_ff   <= 1'b0;
            cmp_sync_ff <= 3'b000;
            cmp_lvl_ff  <= 1'b0;
        end else begin
            rc_sync_ff  <= {rc_sync_ff[1:0], rc_osc};
            cmp_sync_ff <= {cmp_sync_ff[1:0], cmp_in};
            if (rc_sync_ff[1] == rc_sync_ff[2]) begin
                rc_lvl_ff <= rc_sync_ff[2];
            end
            if (cmp_sync_ff[1] == cmp_sync_ff[2]) begin
                cmp_lvl_ff <= cmp_sync_ff[2];
            end
        end
    end

    assign rc_rise   = rc_sync_ff[1] & rc_sync_ff[2] & ~rc_lvl_ff;
    assign conv_tick = opt_ff[OPT_CONVERTER_CLOCK_SOURCE] ? rc_rise : e_tick_ff;
    assign susp      = stop_mode | wait_mode;
    // results land only in cycles without a bus access
    assign commit    = (state_ff == ST_STORE) && !psel;

    // ---------------- sequencer ----------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            tcnt_ff  <= 4'h0;
            bit_ff   <= 3'd7;
            slot_ff  <= 2'd0;
            sar_ff   <= 8'h00;
        end else if (!opt_ff[OPT_CONVERTER_POWER_UP]) begin
            state_ff <= ST_IDLE;
        end else if (wr_ctl) begin
            // abandon and restart with new settings
            state_ff <= ST_ARM;
            slot_ff  <= 2'd0;
            tcnt_ff  <= 4'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                end
                ST_ARM: begin
                    // start on the next e clock tick
                    if (e_tick_ff) begin
                        state_ff <= ST_SAMPLE;
                        tcnt_ff  <= 4'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (susp) begin
                        state_ff <= ST_SUSP;
                    end else if (conv_tick) begin
                        if (tcnt_ff == 4'(SAMPLE_TICKS - 1)) begin
                            state_ff <= ST_BITS;
                            tcnt_ff  <= 4'h0;
                            bit_ff   <= 3'd7;
                            sar_ff   <= 8'h00;
                        end else begin
                            tcnt_ff <= tcnt_ff + 4'h1;
                        end
                    end
                end
                ST_BITS: begin
                    if (susp) begin
                        state_ff <= ST_SUSP;
                    end else if (conv_tick) begin
                        if (tcnt_ff == 4'(BIT_TICKS - 1)) begin
                            // keep trial bit while input is not lower
                            sar_ff[bit_ff] <= cmp_lvl_ff;
                            tcnt_ff        <= 4'h0;
                            if (bit_ff == 3'd0) begin
                                state_ff <= ST_STORE;
                            end else begin
                                bit_ff <= bit_ff - 3'd1;
                            end
                        end else begin
                            tcnt_ff <= tcnt_ff + 4'h1;
                        end
                    end
                end
                ST_STORE: begin
                    if (commit) begin
                        // four per sequence, slot wraps round-robin
                        slot_ff <= slot_ff + 2'd1;
                        tcnt_ff <= 4'h0;
                        if (slot_ff == 2'd3 && !ctl_ff[CTL_SCAN]) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            state_ff <= ST_SAMPLE;
                        end
                    end
                end
                ST_SUSP: begin
                    // resample the same channel on resume
                    if (!susp) begin
                        state_ff <= ST_SAMPLE;
                        tcnt_ff  <= 4'h0;
                    end
                end
            endcase
        end
    end

    // ---------------- results and control ----------------
    // bus writes never reach results
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < NUM_RES; i++) begin
                res_ff[i] <= 8'h00;
            end
        end else if (commit) begin
            res_ff[slot_ff] <= sar_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl_ff <= CTL_RST;
        end else begin
            if (wr_ctl) begin
                ctl_ff <= (ctl_ff & ~CTL_WR_MASK)
                          | (pwdata[7:0] & CTL_WR_MASK);
                ctl_ff[CTL_CCF] <= 1'b0;
            end
            // set after each fourth result, stays set until a control write
            if (commit && slot_ff == 2'd3) begin
                ctl_ff[CTL_CCF] <= 1'b1;
            end
        end
    end

    // ---------------- analog side drive ----------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mux_sel_ff   <= 4'h0;
            sample_en_ff <= 1'b0;
            dac_code_ff  <= 8'h00;
        end else begin
            // group mode takes upper bits plus slot
            mux_sel_ff   <= ctl_ff[CTL_CHANNEL_GROUP_CTRL] ? {ctl_ff[3:2], slot_ff}
                                             : ctl_ff[3:0];
            sample_en_ff <= (state_ff == ST_SAMPLE);
            dac_code_ff  <= (state_ff == ST_BITS)
                            ? (sar_ff | (8'h01 << bit_ff)) : sar_ff;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_flag_wr_clear: assert property (
        wr_ctl |=> !ctl_ff[CTL_CCF]
                   && state_ff == (opt_ff[OPT_CONVERTER_POWER_UP] ? ST_ARM : ST_IDLE))
        else $error("control write did not clear flag");

    a_bit6_zero: assert property (
        psel && !penable && !pwrite && hit_ctl |=> prdata_ff[CTL_ZERO] == 1'b0)
        else $error("bit 6 read back nonzero");

    a_result_ro: assert property (
        access && pwrite && hit_res |=> res_ff[res_off[3:2]]
                                        == $past(res_ff[res_off[3:2]]))
        else $error("result register changed by write");

    a_update_no_bus: assert property (
        commit |-> !psel ##1 res_ff[$past(slot_ff)] == $past(sar_ff))
        else $error("result stored during bus access");

    a_start_eclk: assert property (
        state_ff == ST_ARM && !e_tick_ff && !wr_ctl && opt_ff[OPT_CONVERTER_POWER_UP]
        |=> state_ff != ST_SAMPLE)
        else $error("sequence started before e tick");

    a_power_down: assert property (
        !opt_ff[OPT_CONVERTER_POWER_UP] |=> state_ff == ST_IDLE ##1 !sample_en_ff)
        else $error("converter active while powered down");

    a_group_chan: assert property (
        ctl_ff[CTL_CHANNEL_GROUP_CTRL]
        |=> mux_sel_ff == {$past(ctl_ff[3:2]), $past(slot_ff)})
        else $error("group channel select wrong");

    a_halt_once: assert property (
        commit && slot_ff == 2'd3 && !ctl_ff[CTL_SCAN] && opt_ff[OPT_CONVERTER_POWER_UP]
        |=> state_ff == ST_IDLE && ctl_ff[CTL_CCF])
        else $error("single pass did not halt with flag");

    a_repeat_on: assert property (
        commit && slot_ff == 2'd3 && ctl_ff[CTL_SCAN] && opt_ff[OPT_CONVERTER_POWER_UP]
        |=> state_ff == ST_SAMPLE && slot_ff == 2'd0 && ctl_ff[CTL_CCF])
        else $error("repeat mode did not continue");

    a_suspend: assert property (
        susp && state_ff == ST_BITS && !wr_ctl && opt_ff[OPT_CONVERTER_POWER_UP]
        |=> state_ff == ST_SUSP ##1 ($past(susp) || state_ff == ST_SAMPLE))
        else $error("suspend not honoured");

    a_opt_lock: assert property (
        wr_opt && !opt_open |=> (opt_ff & OPT_ONCE_MASK)
                                == ($past(opt_ff) & OPT_ONCE_MASK))
        else $error("locked option bit changed");
endmodule

// ==== dv/adsq_analog_model.sv ====
// behavioural analog side: input mux, sample-and-hold, comparator
`timescale 1ns/1ps
module adsq_analog_model (
    input  wire logic        clk_sys,
    input  wire logic [63:0] an_lvl,
    input  wire logic [3:0]  mux_sel,
    input  wire logic        sample_en,
    input  wire logic [7:0]  dac_code,
    input  wire logic        conv_pwr,
    output logic             cmp_in
);
    logic [7:0] src;
    logic [7:0] held_ff = 8'h00;
    logic       tgl_ff  = 1'b0;

    always_comb begin
        if (!mux_sel[3])
            src = an_lvl[{mux_sel[2:0], 3'b000} +: 8];
        else if (mux_sel == 4'hc)
            src = 8'hff;
        else if (mux_sel == 4'he)
            src = 8'h80;
        else
            src = 8'h00;
    end

    always @(posedge clk_sys) begin
        tgl_ff <= ~tgl_ff;
        if (sample_en)
            held_ff <= src;
    end

    // unpowered comparator toggles so a stale answer cannot pass
    // held input against trial code
    assign cmp_in = conv_pwr ? (held_ff >= dac_code) : tgl_ff;
endmodule

// ==== dv/tb_ad_sequencer_control.sv ====
// self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module tb_ad_sequencer_control;
    import adsq_pkg::*;
    localparam int          EDV   = 4;
    localparam logic [15:0] A_CTL = IDX_CTL << 2;
    localparam logic [15:0] A_RES = IDX_RES1 << 2;
    localparam logic [15:0] A_OPT = IDX_OPT << 2;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic        e;
    } adsq_note_t;

    logic        clk_sys = 1'b0;
    logic        rc_osc  = 1'b0;
    logic        reset, psel, penable, pwrite, pready, pslverr;
    logic        special_mode, stop_mode, wait_mode, cmp_in;
    logic        sample_en, conv_pwr, conv_clk_rc;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  mux_sel;
    logic [7:0]  dac_code;
    logic [63:0] an_lvl;
    int          checks     = 0;
    int          mismatches = 0;
    adsq_note_t  notes[$];
    adsq_note_t  nt;

    always #2.5 clk_sys = ~clk_sys;
    // unrelated phase to the system clock
    always #37 rc_osc = ~rc_osc;

    adsq_top #(.E_DIV(EDV)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .rc_osc(rc_osc),
        .cmp_in(cmp_in), .mux_sel(mux_sel), .sample_en(sample_en),
        .dac_code(dac_code), .conv_pwr(conv_pwr),
        .conv_clk_rc(conv_clk_rc));

    adsq_analog_model u_ana (
        .clk_sys(clk_sys), .an_lvl(an_lvl), .mux_sel(mux_sel),
        .sample_en(sample_en), .dac_code(dac_code), .conv_pwr(conv_pwr),
        .cmp_in(cmp_in));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp_data(input logic [31:0] e, m, s);
        checks++;
        if (((e ^ s) & m) !== 32'h0) begin
            mismatches++;
            $display("[ERR] prdata exp %h seen %h", e, s);
        end
    endtask

    task automatic cmp_pin(input string n, input logic e, s);
        checks++;
        if (e !== s) begin
            mismatches++;
            $display("[ERR] %s exp %b seen %b", n, e, s);
        end
    endtask

    task automatic hang(input string n);
        mismatches++;
        $display("[ERR] %s exp answer seen none", n);
        test_done();
    endtask

    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d, e, m, input logic er,
                       output logic [31:0] q);
        int n;
        notes.push_back('{e, m, er});
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            hang("pready");
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, q);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, e, 32'hffff_ffff, 1'b0, q);
    endtask

    // polls while checking the settings bits; flag left free
    task automatic wait_flag(input logic [7:0] c);
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            apb(1'b0, A_CTL, 32'h0, {26'h0, c[5:0]}, 32'hffff_ff7f, 1'b0, q);
            n++;
        end while (q[7] !== 1'b1 && n < 3000);
        if (q[7] !== 1'b1)
            hang("conversions_complete_flag");
    endtask

    task automatic wait_samples(input int k, output int n);
        logic p;
        n = 0;
        p = sample_en;
        while (k > 0 && n < 5000) begin
            @(posedge clk_sys);
            n++;
            if (sample_en === 1'b1 && p !== 1'b1)
                k--;
            p = sample_en;
        end
        if (k > 0)
            hang("sample_en");
    endtask

    function automatic logic [7:0] lvl(input logic [3:0] c);
        if (!c[3])
            return an_lvl[{c[2:0], 3'b000} +: 8];
        return (c == 4'hc) ? 8'hff : (c == 4'he) ? 8'h80 : 8'h00;
    endfunction

    task automatic chk_res(input logic [7:0] c);
        for (int i = 0; i < NUM_RES; i++)
            rd(A_RES + 16'(4 * i),
               {24'h0, lvl(c[4] ? {c[3:2], 2'(i)} : c[3:0])});
    endtask

    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            cmp_data(nt.d, nt.m, prdata);
            cmp_pin("pslverr", nt.e, pslverr);
        end
    end

    initial begin
        logic [7:0]  c;
        logic [31:0] q;
        int          n;
        {reset, psel, penable, pwrite} = 4'h8;
        {special_mode, stop_mode, wait_mode} = 3'h0;
        paddr  = 16'h0;
        pwdata = 32'h0;
        an_lvl = 64'h0;
        q      = $urandom(58979);
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(A_CTL, {24'h0, CTL_RST});
        rd(A_OPT, {24'h0, OPT_RST});
        rd(A_RES, 32'h0);
        wr(A_OPT, 32'h85);
        wr(A_OPT, 32'hb2);
        rd(A_OPT, 32'h85);
        cmp_pin("conv_pwr", 1'b1, conv_pwr);
        repeat (20000) @(posedge clk_sys);
        special_mode <= 1'b1;
        wr(A_OPT, 32'h92);
        rd(A_OPT, 32'h92);
        special_mode <= 1'b0;
        $display("test options done");
        for (int m = 0; m < 5; m++) begin
            c = (m < 4) ? {2'b00, 2'(m), 1'b0, 3'($urandom_range(7))} : 8'h1c;
            an_lvl <= {$urandom(), $urandom()};
            if (m == 4)
                wr(A_OPT, 32'hc0);
            wr(A_CTL, ($urandom() & 32'hffff_ffc0) | {24'h0, c});
            rd(A_CTL, {26'h0, c[5:0]});
            cmp_pin("conv_clk_rc", m == 4, conv_clk_rc);
            wait_flag(c);
            chk_res(c);
            if (c[5]) begin
                an_lvl <= ~an_lvl;
                wait_samples(5, n);
                chk_res(c);
                rd(A_CTL, {26'h2, c[5:0]});
            end
            $display("test mode %0d done", m);
        end
        wr(A_OPT, 32'h80);
        an_lvl <= {$urandom(), $urandom()};
        wr(A_CTL, 32'h01);
        wait_samples(1, n);
        cmp_pin("start", n >= 2 && n <= EDV + 3, 1'b1);
        wait_samples(1, n);
        wr(A_CTL, 32'h06);
        wait_flag(8'h06);
        chk_res(8'h06);
        $display("test restart done");
        // start-up delay bit stays set, so no settle wait
        for (int k = 0; k < 2; k++) begin
            wr(A_CTL, 32'h03);
            wait_samples(1, n);
            // lands inside the bit decisions of the first slot
            repeat (SAMPLE_TICKS * EDV + 8) @(posedge clk_sys);
            {stop_mode, wait_mode} <= 2'b01 << k;
            an_lvl[31:24] <= ~an_lvl[31:24];
            repeat (100) @(posedge clk_sys);
            cmp_pin("sample_en", 1'b0, sample_en);
            {stop_mode, wait_mode} <= 2'b00;
            wait_flag(8'h03);
            chk_res(8'h03);
        end
        $display("test suspend done");
        wr(A_RES + 16'h4, 32'h3c);
        rd(A_RES + 16'h4, {24'h0, lvl(4'h3)});
        apb(1'b1, 16'h4100, 32'h5, 32'h0, 32'h0, 1'b1, q);
        apb(1'b0, 16'h4100, 32'h0, 32'h0, 32'hffff_ffff, 1'b1, q);
        $display("test map done");
        wr(A_CTL, 32'h02);
        wait_samples(1, n);
        // power-down lands inside a running sequence
        wr(A_OPT, 32'h00);
        wr(A_CTL, 32'h02);
        repeat (600) @(posedge clk_sys);
        cmp_pin("sample_en", 1'b0, sample_en);
        rd(A_CTL, 32'h02);
        cmp_pin("conv_pwr", 1'b0, conv_pwr);
        $display("test power done");
        test_done();
    end
endmodule
